//--- core/capcmp_regs.vh
// Constants for the capture/compare module: widths, field values, counts
`ifndef CAPCMP_REGS_VH
`define CAPCMP_REGS_VH
`define CNT_W 16
`define BYTE_W 8
`define LEN_8 2'b00
`define LEN_9 2'b01
`define LEN_10 2'b10
`define LEN_11 2'b11
`define OVF_BIT_8 4'h7
`define OVF_BIT_9 4'h8
`define OVF_BIT_10 4'h9
`define OVF_BIT_11 4'hA
`define SYNC_STAGES 2
`define ZERO16 16'h0000
`define ZERO8 8'h00
`define ONES16 16'hFFFF
`endif

//--- core/pin_sync.v
// Two-stage synchroniser for the module pin input
`default_nettype none
module pin_sync (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire din,
	output wire dout
);
	reg meta_q;
	reg sync_q;
	// ----------------------------------------
	// Synchroniser chain; first stage read only by the second
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else if (ce) begin
			meta_q <= din;
			sync_q <= meta_q;
		end
	end
	assign dout = sync_q;
endmodule
`default_nettype wire

//--- core/edge_detect.v
// Edge detector selecting rising, falling or both edges
`default_nettype none
module edge_detect (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire level,
	input wire rise_en,
	input wire fall_en,
	output wire hit
);
	reg prev_q;
	// ----------------------------------------
	// Previous level of the synchronised pin
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_q <= 1'b0;
		end else if (ce) begin
			prev_q <= level;
		end
	end
	// Edge selection by the two enable bits
	assign hit = (rise_en & level & ~prev_q) |
		(fall_en & ~level & prev_q);
endmodule
`default_nettype wire

//--- core/capture_compare.v
// One capture/compare module of the counter array
`default_nettype none
`include "capcmp_regs.vh"
module capture_compare #(
	parameter CNT_W = `CNT_W
) (
	input wire ref_clk,
	input wire arst_n,
	input wire ce,
	input wire [15:0] counter_value,
	input wire counter_tick,
	input wire [1:0] cycle_length_field,
	input wire reload_register_select,
	input wire rising_edge_capture_enable,
	input wire falling_edge_capture_enable,
	input wire match_flag_enable,
	input wire toggle_enable,
	input wire pwm_select,
	input wire wide_pwm_select,
	input wire flag_interrupt_enable,
	input wire overflow_interrupt_enable,
	input wire [7:0] wr_data,
	input wire wr_low,
	input wire wr_high,
	input wire comparator_enable_wr,
	input wire comparator_enable_wdata,
	input wire flag_clear,
	input wire module_io_pin_in,
	output reg module_io_pin_out,
	output wire module_io_pin_oe_n,
	output reg [7:0] compare_low_byte,
	output reg [7:0] compare_high_byte,
	output wire comparator_enable,
	output wire module_event_flag,
	output wire cycle_overflow_flag,
	output wire pin_level,
	output wire irq
);
	reg [15:0] cap_q;
	reg [15:0] reload_q;
	reg ecom_q;
	reg flag_q;
	reg cycle_overflow_flag_q;
	reg pin_q;
	reg pwm_last_q;
	wire pin_s;
	wire edge_hit;
	wire cap_mode;
	wire timer_mode;
	wire hso_mode;
	wire freq_mode;
	wire pwm_short;
	wire pwm_long;
	wire match16;
	wire match8;
	wire nmatch;
	wire ovf_short;
	wire ovf16;
	wire event_set;
	reg [3:0] ovf_bit;
	reg [15:0] len_mask;
	wire [7:0] step;

	assign comparator_enable = ecom_q;
	assign module_event_flag = flag_q;
	assign cycle_overflow_flag = cycle_overflow_flag_q;

	// ----------------------------------------
	// Pin input path
	// ----------------------------------------
	// Two flops only synchronise; a one-clock pulse that is sampled still passes
	pin_sync u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.din(module_io_pin_in),
		.dout(pin_s)
	);
	edge_detect u_edge (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ce(ce),
		.level(pin_s),
		.rise_en(rising_edge_capture_enable),
		.fall_en(falling_edge_capture_enable),
		.hit(edge_hit)
	);
	// Live level lets software tell which edge fired
	assign pin_level = pin_s;

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	assign cap_mode = (rising_edge_capture_enable |
		falling_edge_capture_enable) & ~toggle_enable & ~pwm_select;
	assign timer_mode = ~cap_mode & ~toggle_enable & ~pwm_select &
		match_flag_enable & ~wide_pwm_select;
	assign hso_mode = toggle_enable & ~pwm_select & match_flag_enable;
	assign freq_mode = toggle_enable & pwm_select;
	assign pwm_long = pwm_select & ~toggle_enable & wide_pwm_select;
	// Shared length field, no per-module length
	assign pwm_short = pwm_select & ~toggle_enable & ~wide_pwm_select;
	// Pin is always driven by the module outside capture
	assign module_io_pin_oe_n = cap_mode;

	// Overflow bit and compare mask from the length field
	always @* begin
		case (cycle_length_field)
		`LEN_8: begin
			ovf_bit = `OVF_BIT_8;
		end
		`LEN_9: begin
			ovf_bit = `OVF_BIT_9;
		end
		`LEN_10: begin
			ovf_bit = `OVF_BIT_10;
		end
		default: begin
			ovf_bit = `OVF_BIT_11;
		end
		endcase
		len_mask = ~(`ONES16 << (ovf_bit + 4'h1));
	end

	// ----------------------------------------
	// Comparators, using this cycle's counter value
	// ----------------------------------------
	assign match16 = ecom_q & counter_tick & (counter_value == cap_q);
	assign match8 = ecom_q & counter_tick &
		(counter_value[7:0] == cap_q[7:0]);
	assign nmatch = ecom_q & counter_tick &
		((counter_value & len_mask) == (cap_q & len_mask));
	// Overflow out of bit N: low N+1 bits all ones before the tick
	assign ovf_short = counter_tick &
		((counter_value & len_mask) == len_mask);
	assign ovf16 = counter_tick & (counter_value == `ONES16);
	// Step comes from the live register, not the lagging readback copy
	assign step = cap_q[15:8];

	// Flag sources: capture, or enabled match
	assign event_set = (cap_mode & edge_hit) |
		(match_flag_enable & ~cap_mode &
		(freq_mode ? match16 : (pwm_short ? nmatch : match16)));

	// ----------------------------------------
	// Register and flag state
	// ----------------------------------------
	// Byte writes go to capture or reload storage
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_q <= `ZERO16;
			reload_q <= `ZERO16;
			ecom_q <= 1'b0;
			flag_q <= 1'b0;
			cycle_overflow_flag_q <= 1'b0;
		end else if (ce) begin
			if (wr_low & reload_register_select) begin
				reload_q[7:0] <= wr_data;
			end else if (wr_low) begin
				cap_q[7:0] <= wr_data;
			end else if (cap_mode & edge_hit) begin
				cap_q <= counter_value;
			end else if (freq_mode & match8) begin
				cap_q[7:0] <= cap_q[7:0] + step;
			end else if (pwm_short & ovf_short) begin
				cap_q <= (cycle_length_field == `LEN_8) ?
					{cap_q[15:8], cap_q[15:8]} : reload_q;
			end
			if (wr_high & reload_register_select) begin
				reload_q[15:8] <= wr_data;
			end else if (wr_high) begin
				cap_q[15:8] <= wr_data;
			end
			// Low write clears, high write sets
			if (wr_high) begin
				ecom_q <= 1'b1;
			end else if (wr_low) begin
				ecom_q <= 1'b0;
			end else if (comparator_enable_wr) begin
				ecom_q <= comparator_enable_wdata;
			end
			// Set beats clear; only software clears
			if (event_set) begin
				flag_q <= 1'b1;
			end else if (flag_clear) begin
				flag_q <= 1'b0;
			end
			if (pwm_short & ovf_short) begin
				cycle_overflow_flag_q <= 1'b1;
			end else if (flag_clear) begin
				cycle_overflow_flag_q <= 1'b0;
			end
		end
	end

	// Readback of the byte pair that reload select points at
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_low_byte <= `ZERO8;
			compare_high_byte <= `ZERO8;
		end else if (ce) begin
			compare_low_byte <= reload_register_select ?
				reload_q[7:0] : cap_q[7:0];
			compare_high_byte <= reload_register_select ?
				reload_q[15:8] : cap_q[15:8];
		end
	end

	// ----------------------------------------
	// Pin output
	// ----------------------------------------
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_q <= 1'b0;
			pwm_last_q <= 1'b0;
			module_io_pin_out <= 1'b0;
		end else if (ce) begin
			if (hso_mode & match16) begin
				pin_q <= ~pin_q;
			end else if (freq_mode & match8) begin
				// Period of 2*step array clocks; zero wraps as 256
				pin_q <= ~pin_q;
			end else if (pwm_short & ~ecom_q) begin
				pin_q <= 1'b0;
			end else if (pwm_short & ovf_short) begin
				pin_q <= 1'b0;
			end else if (pwm_short &
				((cycle_length_field == `LEN_8) ? match8 : nmatch)) begin
				pin_q <= 1'b1;
			end else if (pwm_long & ~ecom_q) begin
				pin_q <= 1'b0;
			end else if (pwm_long & ovf16) begin
				pin_q <= 1'b0;
			end else if (pwm_long & match16) begin
				pin_q <= 1'b1;
			end
			pwm_last_q <= pwm_short | pwm_long;
			module_io_pin_out <= pin_q;
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	assign irq = (flag_interrupt_enable & flag_q) |
		(overflow_interrupt_enable & cycle_overflow_flag_q);
endmodule
`default_nettype wire

//--- testbench/pin_src.sv
// Model of the external source on the module pin
`default_nettype none
module pin_src (
	input wire logic oe_n,
	input wire logic drv,
	input wire logic lvl,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// Source drives only while the module has released the pin
	assign pin = oe_n ? lvl : drv;
endmodule
`default_nettype wire

//--- testbench/capcmp_checker.sv
// Port checker for the capture/compare module
`default_nettype none
module capcmp_checker (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic wr_low,
	input wire logic wr_high,
	input wire logic comparator_enable_wr,
	input wire logic flag_clear,
	input wire logic rising_edge_capture_enable,
	input wire logic falling_edge_capture_enable,
	input wire logic toggle_enable,
	input wire logic pwm_select,
	input wire logic flag_interrupt_enable,
	input wire logic module_io_pin_in,
	input wire logic module_io_pin_out,
	input wire logic module_io_pin_oe_n,
	input wire logic comparator_enable,
	input wire logic module_event_flag,
	input wire logic pin_level,
	input wire logic irq
);
	// ----
	// Properties
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	wire cap = !toggle_enable && !pwm_select;
	a_low_clears: assert property (ce && wr_low && !comparator_enable_wr
		|=> !comparator_enable) else $error("low write kept enable");
	a_high_sets: assert property (ce && wr_high && !wr_low
		&& !comparator_enable_wr |=> comparator_enable)
		else $error("high write left enable off");
	a_flag_holds: assert property (module_event_flag && !flag_clear
		|=> module_event_flag) else $error("flag dropped");
	a_irq_flag: assert property (module_event_flag
		&& flag_interrupt_enable |-> irq) else $error("no request");
	a_hold_off: assert property ((toggle_enable && !comparator_enable)[*3]
		|=> $stable(module_io_pin_out)) else $error("pin moved");
	a_pwm_zero: assert property ((ce && pwm_select && !toggle_enable
		&& !comparator_enable)[*3] |-> !module_io_pin_out)
		else $error("pwm not zero");
	a_cap_input: assert property (cap && (rising_edge_capture_enable
		|| falling_edge_capture_enable) |-> module_io_pin_oe_n)
		else $error("pin driven in capture");
	a_pin_sync: assert property (ce[*3]
		|-> pin_level == $past(module_io_pin_in, 2))
		else $error("pin level lags");
	a_cap_flag: assert property (ce && cap
		&& (rising_edge_capture_enable && $rose(pin_level)
		|| falling_edge_capture_enable && $fell(pin_level))
		|-> ##[0:2] module_event_flag) else $error("capture lost");
	c_cap: cover property (cap && module_event_flag);
	c_tog: cover property ($changed(module_io_pin_out));
	c_irq: cover property ($rose(irq));
endmodule
bind capture_compare capcmp_checker u_chk (.*);
`default_nettype wire

//--- testbench/capture_compare_tb_top.sv
// Self-checking bench for the capture/compare module
`default_nettype none
module capture_compare_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Signals carry the port names so the instance binds by name
	// ----
	logic ref_clk, arst_n, ce, counter_tick, pin_level, irq, lvl;
	logic rising_edge_capture_enable, falling_edge_capture_enable;
	logic match_flag_enable, toggle_enable, pwm_select;
	logic flag_interrupt_enable, overflow_interrupt_enable;
	logic wr_low, wr_high, flag_clear, module_io_pin_in;
	logic module_io_pin_out, module_io_pin_oe_n, comparator_enable;
	logic module_event_flag, cycle_overflow_flag;
	logic [15:0] counter_value;
	logic [7:0] wr_data, compare_low_byte, compare_high_byte;
	// Wide PWM and direct enable writes lie outside these scenarios; length and reload select start at zero
	logic [1:0] cycle_length_field = 2'b00;
	logic reload_register_select = 1'b0, wide_pwm_select = 1'b0;
	logic comparator_enable_wr = 1'b0, comparator_enable_wdata = 1'b0;
	int mismatches, checks, cyc;
	typedef struct packed {
		logic [15:0] val;
		logic [15:0] cnt;
		logic tick;
		logic flag;
	} row_t;
	row_t rows [4] = '{'{16'h1234, 16'h1234, 1'b1, 1'b1},
		'{16'h1234, 16'h1235, 1'b1, 1'b0},
		'{16'hFFFF, 16'hFFFF, 1'b0, 1'b0},
		'{16'hFFFF, 16'hFFFF, 1'b1, 1'b1}};
	capture_compare dut (.*);
	pin_src u_src (.oe_n(module_io_pin_oe_n), .drv(module_io_pin_out),
		.lvl(lvl), .pin(module_io_pin_in));
	// ----
	// Helpers
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic setm(input logic [4:0] m);
		@(posedge ref_clk);
		{rising_edge_capture_enable, falling_edge_capture_enable,
			match_flag_enable, toggle_enable, pwm_select} <= m;
	endtask
	task automatic wlo(input logic [7:0] d);
		@(posedge ref_clk);
		wr_data <= d;
		wr_low <= 1'b1;
		@(posedge ref_clk);
		wr_low <= 1'b0;
	endtask
	// Low byte goes first so the enable ends up set
	task automatic wr16(input logic [15:0] v);
		wlo(v[7:0]);
		wr_data <= v[15:8];
		wr_high <= 1'b1;
		@(posedge ref_clk);
		wr_high <= 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic clr;
		@(posedge ref_clk);
		flag_clear <= 1'b1;
		@(posedge ref_clk);
		flag_clear <= 1'b0;
	endtask
	task automatic run(input logic [15:0] c, input logic t);
		@(posedge ref_clk);
		counter_value <= c;
		counter_tick <= t;
		@(posedge ref_clk);
		counter_tick <= 1'b0;
		@(negedge ref_clk);
	endtask
	// Counts pin toggles while the counter runs from zero
	task automatic freq(input logic [7:0] hi, input int n, input int ne);
		logic last;
		int tg;
		setm(5'b00011);
		wr16({hi, 8'h00});
		last = module_io_pin_out;
		tg = 0;
		for (int i = 0; i < n + 3; i++) begin
			@(posedge ref_clk);
			counter_value <= i[15:0];
			counter_tick <= (i < n);
			@(negedge ref_clk);
			tg += int'(module_io_pin_out !== last);
			last = module_io_pin_out;
		end
		chk(tg[15:0], ne[15:0]);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Cuts a hang short well past the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			close_out;
		end
	end
	initial begin
		{arst_n, counter_tick, wr_low, wr_high, flag_clear, lvl} = '0;
		ce = 1'b1;
		counter_value = 16'h0000;
		wr_data = 8'h00;
		{rising_edge_capture_enable, falling_edge_capture_enable} = '0;
		{match_flag_enable, toggle_enable, pwm_select} = '0;
		flag_interrupt_enable = 1'b1;
		overflow_interrupt_enable = 1'b1;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		chk(module_event_flag, 1'b0);
		chk(comparator_enable, 1'b0);
		setm(5'b00100);
		foreach (rows[i]) begin
			wr16(rows[i].val);
			chk(comparator_enable, 1'b1);
			run(rows[i].cnt, rows[i].tick);
			chk(module_event_flag, rows[i].flag);
			chk(irq, rows[i].flag);
			clr;
		end
		chk(compare_high_byte, 8'hFF);
		@(posedge ref_clk);
		reload_register_select <= 1'b1;
		wr16(16'hA55A);
		@(negedge ref_clk);
		chk({compare_high_byte, compare_low_byte}, 16'hA55A);
		@(posedge ref_clk);
		reload_register_select <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({compare_high_byte, compare_low_byte}, 16'hFFFF);
		setm(5'b00110);
		wr16(16'h0040);
		run(16'h0040, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk(module_io_pin_out, 1'b1);
		chk(module_io_pin_oe_n, 1'b0);
		chk(module_event_flag, 1'b1);
		clr;
		wlo(8'h40);
		run(16'h0040, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk(module_io_pin_out, 1'b1);
		chk(comparator_enable, 1'b0);
		setm(5'b00001);
		repeat (4) @(negedge ref_clk);
		chk(module_io_pin_out, 1'b0);
		// Ten-bit length: an eight-bit rollover must not count
		@(posedge ref_clk);
		cycle_length_field <= 2'b10;
		run(16'h00FF, 1'b1);
		chk(cycle_overflow_flag, 1'b0);
		run(16'h03FF, 1'b1);
		chk(cycle_overflow_flag, 1'b1);
		chk(irq, 1'b1);
		clr;
		cycle_length_field <= 2'b00;
		for (int k = 1; k < 4; k++) begin
			setm({k[1], k[0], 3'b000});
			repeat (4) @(posedge ref_clk);
			clr;
			for (int e = 0; e < 2; e++) begin
				@(posedge ref_clk);
				lvl <= !lvl;
				repeat (5) @(negedge ref_clk);
				chk(module_event_flag, lvl ? k[1] : k[0]);
				chk(pin_level, lvl);
				clr;
			end
		end
		freq(8'h02, 64, 32);
		freq(8'h00, 512, 2);
		freq(8'h01, 16, 16);
		close_out;
	end
endmodule
`default_nettype wire
